// [bench/pin_model.sv]
`timescale 1ns/1ps
module pin_model (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic rst_lvl,
    input  wire logic trg_lvl,
    output logic      ext_count_clock_pin,
    output logic      ext_counter_reset_pin,
    output logic      trigger_pin
);
    logic [1:0] cnt_reg;
    initial begin
        cnt_reg = 2'h0;
        ext_count_clock_pin = 1'b0;
    end
    // Clock toggles every 4 cycles in a burst, stands still outside
    always @(posedge clk) begin
        cnt_reg <= run ? cnt_reg + 2'h1 : 2'h0;
        if (run && cnt_reg == 2'h3) begin
            ext_count_clock_pin <= ~ext_count_clock_pin;
        end
    end
    assign ext_counter_reset_pin = rst_lvl;
    assign trigger_pin           = trg_lvl;
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
`include "timer_consts.svh"
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        low_power = 1'b0;
    logic        en = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [7:0]  rdata;
    logic        irq_a;
    logic        irq_b;
    logic        irq_w;
    logic        wave;
    logic        run = 1'b0;
    logic        rst_lvl = 1'b0;
    logic        trg_lvl = 1'b0;
    logic        p_clk;
    logic        p_rst;
    logic        p_trg;
    logic [7:0]  v;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;

    always #4 clk = ~clk;

    eight_bit_compare_timer dut_u (.clk(clk), .rst(rst), .clk_en(en), .low_power(low_power),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .match_irq_a(irq_a), .match_irq_b(irq_b), .wrap_irq(irq_w), .waveform_out_pin(wave),
        .ext_count_clock_pin(p_clk), .ext_counter_reset_pin(p_rst), .trigger_pin(p_trg));

    pin_model pm_u (.clk(clk), .run(run), .rst_lvl(rst_lvl), .trg_lvl(trg_lvl),
        .ext_count_clock_pin(p_clk), .ext_counter_reset_pin(p_rst), .trigger_pin(p_trg));

    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic edges(input int n);
        @(posedge clk);
        run <= 1'b1;
        repeat (8 * n) @(posedge clk);
        run <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic t_reset();
        rchk(`OFS_CTRL0, 8'h00);
        rchk(`OFS_STAT, 8'h10);
        rchk(`OFS_CMPA, 8'hff);
        rchk(`OFS_CMPB, 8'hff);
        rchk(`OFS_COUNT, 8'h00);
        rchk(`OFS_CTRL1, 8'he2);
        rchk(16'hffbe, 8'h00);
        $display("done reset");
    endtask

    task automatic t_ext();
        logic [7:0] codes[5] = '{8'h05, 8'h06, 8'h07, 8'h00, 8'h04};
        logic [7:0] exps[5] = '{8'h03, 8'h03, 8'h06, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            wr(`OFS_CTRL0, codes[i]);
            wr(`OFS_COUNT, 8'h00);
            edges(3);
            rchk(`OFS_COUNT, exps[i]);
        end
        $display("done ext");
    endtask

    task automatic t_presc();
        wr(`OFS_CTRL0, 8'h01);
        wr(`OFS_COUNT, 8'h00);
        repeat (400) @(posedge clk);
        rd(`OFS_COUNT, v);
        chk(8'(v >= 8'd99 && v <= 8'd101), 8'h01);
        wr(`OFS_CTRL1, 8'h01);
        wr(`OFS_CTRL0, 8'h03);
        wr(`OFS_COUNT, 8'h00);
        repeat (512) @(posedge clk);
        rd(`OFS_COUNT, v);
        chk(8'(v >= 8'd3 && v <= 8'd5), 8'h01);
        wr(`OFS_CTRL1, 8'h00);
        $display("done presc");
    endtask

    task automatic t_flags();
        wr(`OFS_CTRL0, 8'he5);
        wr(`OFS_COUNT, 8'hfe);
        edges(2);
        chk({5'h00, irq_a, irq_b, irq_w}, 8'h07);
        wr(`OFS_STAT, 8'h00);
        rchk(`OFS_STAT, 8'hf0);
        wr(`OFS_STAT, 8'hf0);
        rchk(`OFS_STAT, 8'hf0);
        wr(`OFS_STAT, 8'h00);
        rchk(`OFS_STAT, 8'h10);
        chk({7'h00, irq_w}, 8'h00);
        $display("done flags");
    endtask

    task automatic t_match();
        wr(`OFS_STAT, 8'h03);
        wr(`OFS_CMPA, 8'h03);
        wr(`OFS_CTRL0, 8'h4d);
        wr(`OFS_COUNT, 8'h00);
        edges(3);
        chk({6'h00, irq_a, irq_b}, 8'h02);
        chk({7'h00, wave}, 8'h01);
        edges(2);
        rd(`OFS_COUNT, v);
        chk(8'(v >= 8'd1 && v <= 8'd2), 8'h01);
        $display("done match");
    endtask

    task automatic t_gate();
        wr(`OFS_CTRL1, 8'h0c);
        wr(`OFS_COUNT, 8'h00);
        edges(2);
        rchk(`OFS_COUNT, 8'h00);
        trg_lvl <= 1'b1;
        repeat (5) @(posedge clk);
        edges(1);
        rchk(`OFS_COUNT, 8'h01);
        trg_lvl <= 1'b0;
        edges(4);
        rchk(`OFS_COUNT, 8'h00);
        $display("done gate");
    endtask

    task automatic t_pin_clear();
        wr(`OFS_CTRL1, 8'h00);
        wr(`OFS_CTRL0, 8'h1d);
        wr(`OFS_COUNT, 8'h00);
        edges(2);
        rchk(`OFS_COUNT, 8'h02);
        rst_lvl <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(`OFS_COUNT, 8'h00);
        rst_lvl <= 1'b0;
        wr(`OFS_CMPA, 8'h55);
        @(posedge clk);
        low_power <= 1'b1;
        repeat (2) @(posedge clk);
        low_power <= 1'b0;
        rchk(`OFS_CMPA, 8'hff);
        rchk(`OFS_CTRL0, 8'h00);
        $display("done pin clear");
    endtask

    task automatic t_out_levels();
        wr(`OFS_STAT, 8'h09);
        wr(`OFS_CMPA, 8'h02);
        wr(`OFS_CMPB, 8'h04);
        wr(`OFS_CTRL0, 8'h95);
        wr(`OFS_COUNT, 8'h00);
        edges(4);
        chk({6'h00, irq_a, irq_b}, 8'h01);
        chk({7'h00, wave}, 8'h01);
        rchk(`OFS_COUNT, 8'h00);
        edges(2);
        chk({7'h00, wave}, 8'h00);
        rchk(`OFS_COUNT, 8'h02);
        $display("done out levels");
    endtask

    task automatic t_fall_trig();
        wr(`OFS_CTRL1, 8'h14);
        edges(1);
        rchk(`OFS_COUNT, 8'h02);
        trg_lvl <= 1'b1;
        repeat (5) @(posedge clk);
        edges(1);
        rchk(`OFS_COUNT, 8'h02);
        trg_lvl <= 1'b0;
        repeat (5) @(posedge clk);
        edges(1);
        rchk(`OFS_COUNT, 8'h03);
        en <= 1'b0;
        edges(2);
        en <= 1'b1;
        rchk(`OFS_COUNT, 8'h03);
        $display("done fall trigger");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ext();
        t_presc();
        t_flags();
        t_match();
        t_gate();
        t_pin_clear();
        t_out_levels();
        t_fall_trig();
        close_out();
    end
endmodule

// [include/timer_consts.svh]
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// Register offsets
`define OFS_CTRL0  16'hffb8
`define OFS_STAT   16'hffb9
`define OFS_CMPA   16'hffba
`define OFS_CMPB   16'hffbb
`define OFS_COUNT  16'hffbc
`define OFS_CTRL1  16'hffbd

// Reset values
`define RST_CTRL0  8'h00
`define RST_STAT   8'h10
`define RST_CMP    8'hff
`define RST_COUNT  8'h00
`define RST_CTRL1  8'he2

// Fixed read-one bits
`define STAT_FIXED  8'h10
`define CTRL1_FIXED 8'he2

// Status field positions
`define BIT_FLAG_B 7
`define BIT_FLAG_A 6
`define BIT_WRAP   5

`endif

// [include/timer_pkg.sv]
package timer_pkg;

    typedef struct packed {
        logic       match_irq_enable_b;
        logic       match_irq_enable_a;
        logic       wrap_irq_enable;
        logic [1:0] clear_select;
        logic [2:0] clock_select;
    } ctrl0_t;

    typedef struct packed {
        logic [1:0] trigger_edge_sel;
        logic       trigger_gating;
        logic       divider_extra_select;
    } ctrl1_t;

    typedef struct packed {
        logic       match_flag_b;
        logic       match_flag_a;
        logic       wrap_flag;
        logic [1:0] out_sel_b;
        logic [1:0] out_sel_a;
    } status_t;

    typedef enum logic [1:0] {
        RUN_ST  = 2'b01,
        HALT_ST = 2'b10
    } run_state_t;

endpackage

// [verilog/eight_bit_compare_timer.sv]
`timescale 1ns/1ps
`include "timer_consts.svh"

module eight_bit_compare_timer
    import timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        low_power,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [7:0]  rdata,
    output logic             match_irq_a,
    output logic             match_irq_b,
    output logic             wrap_irq,
    output logic             waveform_out_pin,
    input  wire logic        ext_count_clock_pin,
    input  wire logic        ext_counter_reset_pin,
    input  wire logic        trigger_pin
);

    ctrl0_t     ctrl0_reg;
    ctrl1_t     ctrl1_reg;
    status_t    stat_reg;
    status_t    stat_next;
    run_state_t run_reg;
    run_state_t run_next;
    logic [7:0] cmpa_reg;
    logic [7:0] cmpb_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [6:0] presc_reg;
    logic [2:0] seen_reg;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] prev_reg;
    logic       out_reg;
    logic       wr_cmpa_q_reg;
    logic       live_a_q_reg;
    logic       live_b_q_reg;

    wire sreset = rst | low_power;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg  <= 3'h0;
        end else if (clk_en) begin
            sync1_reg <= {trigger_pin, ext_counter_reset_pin, ext_count_clock_pin};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    wire [2:0] rise = sync2_reg & ~prev_reg;
    wire [2:0] fall = ~sync2_reg & prev_reg;

    // edge choice: off, rise, fall, both
    function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
        edge_pick = (sel[0] & r) | (sel[1] & f);
    endfunction

    // Register decode
    wire sel_ctrl0 = (addr == `OFS_CTRL0);
    wire sel_stat  = (addr == `OFS_STAT);
    wire sel_cmpa  = (addr == `OFS_CMPA);
    wire sel_cmpb  = (addr == `OFS_CMPB);
    wire sel_count = (addr == `OFS_COUNT);
    wire sel_ctrl1 = (addr == `OFS_CTRL1);
    wire wr_ctrl0  = wr_stb & sel_ctrl0;
    wire wr_stat   = wr_stb & sel_stat;
    wire wr_cmpa   = wr_stb & sel_cmpa;
    wire wr_cmpb   = wr_stb & sel_cmpb;
    wire wr_count  = wr_stb & sel_count;
    wire wr_ctrl1  = wr_stb & sel_ctrl1;

    // prescaler taps, falling edge of divided clock
    function automatic logic presc_tick(input logic [2:0] cks, input logic x, input logic [6:0] p);
        logic [2:0] idx;
        idx = 3'((cks[1:0] - 2'd1) * 2) + {2'b00, x} + 3'd2;
        presc_tick = &(p | ~7'((8'h01 << idx) - 8'h01));
    endfunction

    wire ext_tick = edge_pick(ctrl0_reg.clock_select[2] ? ctrl0_reg.clock_select[1:0] : 2'b00, rise[0], fall[0]);
    wire int_tick = ~ctrl0_reg.clock_select[2] & (ctrl0_reg.clock_select[1:0] != 2'b00) &
                    presc_tick(ctrl0_reg.clock_select, ctrl1_reg.divider_extra_select, presc_reg);
    wire tick     = (ext_tick | int_tick) & (run_reg == RUN_ST);

    wire trig_edge = edge_pick(ctrl1_reg.trigger_edge_sel, rise[2], fall[2]);

    // compare, A paused in write cycle and the cycle after
    wire eq_a    = (count_reg == cmpa_reg);
    wire live_a  = eq_a & ~wr_cmpa & ~wr_cmpa_q_reg;
    wire eq_b    = (count_reg == cmpb_reg);
    // Match is the start of equality only
    wire match_a = live_a & ~live_a_q_reg;
    wire match_b = eq_b & ~live_b_q_reg;
    wire wrap    = tick & (count_reg == 8'hff);

    wire clr = (ctrl0_reg.clear_select == 2'b01) ? match_a :
               (ctrl0_reg.clear_select == 2'b10) ? match_b :
               (ctrl0_reg.clear_select == 2'b11) ? rise[1] : 1'b0;

    assign count_next = wr_count ? wdata :
                        clr      ? 8'h00 :
                        tick     ? 8'(count_reg + 8'h01) : count_reg;

    always_comb begin
        run_next = run_reg;
        unique case (run_reg)
            RUN_ST: begin
                if (ctrl1_reg.trigger_gating & clr)
                    run_next = HALT_ST;
            end
            HALT_ST: begin
                if (~ctrl1_reg.trigger_gating | trig_edge)
                    run_next = RUN_ST;
            end
            default: run_next = RUN_ST;
        endcase
        if (wr_ctrl1 & wdata[2] & ~ctrl1_reg.trigger_gating)
            run_next = HALT_ST;
    end

    wire [2:0] flag_now  = {stat_reg.match_flag_b, stat_reg.match_flag_a, stat_reg.wrap_flag};
    wire [2:0] flag_set  = {match_b, match_a, wrap};
    wire [2:0] flag_clr  = {3{wr_stat}} & ~wdata[7:5] & seen_reg;
    wire [2:0] flag_new  = flag_set | (flag_now & ~flag_clr);

    always_comb begin
        stat_next = stat_reg;
        {stat_next.match_flag_b, stat_next.match_flag_a, stat_next.wrap_flag} = flag_new;
        if (wr_stat)
            {stat_next.out_sel_b, stat_next.out_sel_a} = wdata[3:0];
    end

    // output, toggle beats high beats low
    wire [1:0] act_a = match_a ? stat_reg.out_sel_a : 2'b00;
    wire [1:0] act_b = match_b ? stat_reg.out_sel_b : 2'b00;
    wire out_next = ((act_a == 2'b11) | (act_b == 2'b11)) ? ~out_reg :
                    ((act_a == 2'b10) | (act_b == 2'b10)) ? 1'b1 :
                    ((act_a == 2'b01) | (act_b == 2'b01)) ? 1'b0 : out_reg;

    always_ff @(posedge clk) begin
        if (sreset) begin
            ctrl0_reg <= `RST_CTRL0;
            stat_reg  <= status_t'(7'h00);
            cmpa_reg  <= `RST_CMP;
            cmpb_reg  <= `RST_CMP;
            count_reg <= `RST_COUNT;
            run_reg   <= RUN_ST;
            seen_reg  <= 3'h0;
            out_reg   <= 1'b0;
            presc_reg <= 7'h00;
            wr_cmpa_q_reg <= 1'b0;
            live_a_q_reg  <= 1'b0;
            live_b_q_reg  <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl0)
                ctrl0_reg <= ctrl0_t'(wdata);
            if (wr_cmpa)
                cmpa_reg <= wdata;
            if (wr_cmpb)
                cmpb_reg <= wdata;
            stat_reg  <= stat_next;
            count_reg <= count_next;
            run_reg   <= run_next;
            out_reg   <= out_next;
            presc_reg <= 7'(presc_reg + 7'h01);
            wr_cmpa_q_reg <= wr_cmpa;
            live_a_q_reg  <= live_a;
            live_b_q_reg  <= eq_b;
            if (rd_stb & sel_stat)
                seen_reg <= flag_now;
            else if (wr_stat)
                seen_reg <= 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst | (low_power & 1'b0))
            ctrl1_reg <= ctrl1_t'(4'h0);
        else if (low_power)
            ctrl1_reg <= ctrl1_t'(4'h0);
        else if (clk_en & wr_ctrl1)
            ctrl1_reg <= ctrl1_t'({wdata[4:2], wdata[0]});
    end

    wire [7:0] rd_mux = sel_ctrl0 ? ctrl0_reg :
                        sel_stat  ? ({stat_reg[6:4], 5'h00} | {4'h0, stat_reg[3:0]} | `STAT_FIXED) :
                        sel_cmpa  ? cmpa_reg :
                        sel_cmpb  ? cmpb_reg :
                        sel_count ? count_reg :
                        sel_ctrl1 ? ({3'h0, ctrl1_reg[3:1], 1'b0, ctrl1_reg[0]} | `CTRL1_FIXED) : 8'h00;

    always_ff @(posedge clk) begin
        if (rst)
            rdata <= 8'h00;
        else if (clk_en)
            rdata <= rd_stb ? rd_mux : 8'h00;
    end

    assign match_irq_b      = ctrl0_reg.match_irq_enable_b & stat_reg.match_flag_b;
    assign match_irq_a      = ctrl0_reg.match_irq_enable_a & stat_reg.match_flag_a;
    assign wrap_irq         = ctrl0_reg.wrap_irq_enable & stat_reg.wrap_flag;
    assign waveform_out_pin = out_reg;

    a_wrap_sets_flag: assert property (@(posedge clk) disable iff (sreset)
        clk_en && wrap |=> stat_reg.wrap_flag)
        else $error("wrap flag not set");
    a_match_a_flag: assert property (@(posedge clk) disable iff (sreset)
        clk_en && match_a |=> stat_reg.match_flag_a)
        else $error("match flag a not set");
    a_irq_b_gate: assert property (@(posedge clk) disable iff (sreset)
        match_irq_b == (ctrl0_reg.match_irq_enable_b && stat_reg.match_flag_b))
        else $error("irq b gate wrong");
    a_one_write_kept: assert property (@(posedge clk) disable iff (sreset)
        clk_en && wr_stat && !stat_reg.wrap_flag && !wrap |=> !stat_reg.wrap_flag)
        else $error("flag set by software");
    a_clear_on_a: assert property (@(posedge clk) disable iff (sreset)
        clk_en && ctrl0_reg.clear_select == 2'b01 && match_a && !wr_count |=> count_reg == 8'h00)
        else $error("clear on a failed");
    a_gate_halts: assert property (@(posedge clk) disable iff (sreset)
        clk_en && ctrl1_reg.trigger_gating && clr && !wr_ctrl1 |=> run_reg == HALT_ST)
        else $error("gated clear not halting");
    a_halt_holds: assert property (@(posedge clk) disable iff (sreset)
        run_reg == HALT_ST && !wr_count && !clr |=> count_reg == $past(count_reg))
        else $error("counter moved while halted");
    a_toggle_out: assert property (@(posedge clk) disable iff (sreset)
        clk_en && match_a && stat_reg.out_sel_a == 2'b11 |=> waveform_out_pin != $past(waveform_out_pin))
        else $error("toggle missing");
    a_lowpower_zero: assert property (@(posedge clk)
        low_power |=> count_reg == 8'h00 && cmpa_reg == 8'hff)
        else $error("low power reset failed");

    a_match_b_flag: assert property (@(posedge clk) disable iff (sreset)
        clk_en && match_b |=> stat_reg.match_flag_b)
        else $error("match flag b not set");

    a_irq_a_gate: assert property (@(posedge clk) disable iff (sreset)
        clk_en && match_a && ctrl0_reg.match_irq_enable_a && !wr_ctrl0 |=> match_irq_a)
        else $error("irq a missing");

    a_irq_w_gate: assert property (@(posedge clk) disable iff (sreset)
        clk_en && wrap && ctrl0_reg.wrap_irq_enable && !wr_ctrl0 |=> wrap_irq)
        else $error("wrap irq missing");

    a_irq_b_off: assert property (@(posedge clk) disable iff (sreset)
        !ctrl0_reg.match_irq_enable_b |-> !match_irq_b)
        else $error("irq b while disabled");

    a_count_write: assert property (@(posedge clk) disable iff (sreset)
        clk_en && wr_count |=> count_reg == $past(wdata))
        else $error("count write lost");

    a_count_step: assert property (@(posedge clk) disable iff (sreset)
        clk_en && tick && !wr_count && !clr |=> count_reg == 8'($past(count_reg) + 8'h01))
        else $error("count step wrong");

    a_idle_hold: assert property (@(posedge clk) disable iff (sreset)
        clk_en && !tick && !wr_count && !clr |=> count_reg == $past(count_reg))
        else $error("count moved without tick");

    a_off_codes: assert property (@(posedge clk) disable iff (sreset)
        ctrl0_reg.clock_select == 3'b000 || ctrl0_reg.clock_select == 3'b100 |-> !tick)
        else $error("tick with clock off");

    a_presc_ext: assert property (@(posedge clk) disable iff (sreset)
        ctrl0_reg.clock_select[2] |-> !int_tick)
        else $error("prescaler tick in external mode");

    a_wrap_zero: assert property (@(posedge clk) disable iff (sreset)
        clk_en && wrap && !wr_count && !clr |=> count_reg == 8'h00)
        else $error("wrap not to zero");

    a_ctrl0_reset: assert property (@(posedge clk)
        sreset |=> ctrl0_reg == 8'h00)
        else $error("control zero not cleared");

    a_cmp_reset: assert property (@(posedge clk)
        sreset |=> cmpa_reg == 8'hff && cmpb_reg == 8'hff)
        else $error("compare not all ones");

    a_count_reset: assert property (@(posedge clk)
        sreset |=> count_reg == 8'h00)
        else $error("count not zero after reset");

    a_out_reset: assert property (@(posedge clk)
        sreset |=> !waveform_out_pin)
        else $error("waveform not low after reset");

    a_cmpa_pause: assert property (@(posedge clk) disable iff (sreset)
        wr_cmpa |-> !match_a)
        else $error("compare a during write");

    a_clear_on_b: assert property (@(posedge clk) disable iff (sreset)
        clk_en && ctrl0_reg.clear_select == 2'b10 && match_b && !wr_count |=> count_reg == 8'h00)
        else $error("clear on b failed");

    a_clear_on_pin: assert property (@(posedge clk) disable iff (sreset)
        clk_en && ctrl0_reg.clear_select == 2'b11 && rise[1] && !wr_count |=> count_reg == 8'h00)
        else $error("clear on pin failed");

    a_no_clear: assert property (@(posedge clk) disable iff (sreset)
        ctrl0_reg.clear_select == 2'b00 |-> !clr)
        else $error("clear while disabled");

    a_ungated_runs: assert property (@(posedge clk) disable iff (sreset)
        clk_en && !ctrl1_reg.trigger_gating && !wr_ctrl1 |=> run_reg == RUN_ST)
        else $error("halted without gating");

    a_trig_resume: assert property (@(posedge clk) disable iff (sreset)
        clk_en && run_reg == HALT_ST && trig_edge && !wr_ctrl1 |=> run_reg == RUN_ST)
        else $error("trigger did not restart");

    a_trig_off: assert property (@(posedge clk) disable iff (sreset)
        ctrl1_reg.trigger_edge_sel == 2'b00 |-> !trig_edge)
        else $error("trigger edge while off");

    a_high_out: assert property (@(posedge clk) disable iff (sreset)
        clk_en && (act_a == 2'b10 || act_b == 2'b10) && act_a != 2'b11 && act_b != 2'b11 |=> waveform_out_pin)
        else $error("output not high");

    a_low_out: assert property (@(posedge clk) disable iff (sreset)
        clk_en && (act_a == 2'b01 || act_b == 2'b01) && !act_a[1] && !act_b[1] |=> !waveform_out_pin)
        else $error("output not low");

    a_keep_out: assert property (@(posedge clk) disable iff (sreset)
        clk_en && !match_a && !match_b |=> waveform_out_pin == $past(waveform_out_pin))
        else $error("output moved without match");

    a_flag_held: assert property (@(posedge clk) disable iff (sreset)
        clk_en && stat_reg.match_flag_b && !seen_reg[2] |=> stat_reg.match_flag_b)
        else $error("unseen flag cleared");

    a_sync_first: assert property (@(posedge clk) disable iff (sreset)
        clk_en && trigger_pin |=> sync1_reg[2])
        else $error("trigger not sampled");

    a_freeze_hold: assert property (@(posedge clk) disable iff (sreset)
        !clk_en |=> count_reg == $past(count_reg) && run_reg == $past(run_reg))
        else $error("state moved while frozen");

    c_wrap: cover property (@(posedge clk) disable iff (sreset) wrap);
    c_halt_resume: cover property (@(posedge clk) disable iff (sreset) run_reg == HALT_ST ##1 run_reg == RUN_ST);
    c_flag_clear: cover property (@(posedge clk) disable iff (sreset) stat_reg.match_flag_a ##1 !stat_reg.match_flag_a);
    c_match_b: cover property (@(posedge clk) disable iff (sreset) match_b);
    c_pin_clear: cover property (@(posedge clk) disable iff (sreset) clr && ctrl0_reg.clear_select == 2'b11);

endmodule
